// [core/uv_ol_pkg.sv]
/*
  Constants for the undervoltage force limit and overload timing block:
  register offsets, setting ranges, reset values and timing counts.
  Assumes a 40 MHz core clock and a 1 ms setting unit.
*/
package uv_ol_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PCT_W = 7;
  localparam int unsigned TIME_W = 10;
  localparam int unsigned CUR_W = 10;
  localparam int unsigned NEV = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DIP = 8'h04;
  localparam logic [7:0] OFS_REL = 8'h08;
  localparam logic [7:0] OFS_HOLD = 8'h0c;
  localparam logic [7:0] OFS_WLVL = 8'h10;
  localparam logic [7:0] OFS_DERATE = 8'h14;
  localparam logic [7:0] OFS_RESTART = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_LIMIT = 8'h28;
  localparam logic [7:0] OFS_ACC = 8'h2c;

  // ----------------------------------------------------------------
  // Setting ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] DIP_MIN = 10'h000;
  localparam logic [9:0] DIP_MAX = 10'h064;
  localparam logic [9:0] DIP_RST = 10'h032;
  localparam logic [9:0] REL_MIN = 10'h000;
  localparam logic [9:0] REL_MAX = 10'h3e8;
  localparam logic [9:0] REL_RST = 10'h064;
  localparam logic [9:0] HOLD_MIN = 10'h014;
  localparam logic [9:0] HOLD_MAX = 10'h3e8;
  localparam logic [9:0] HOLD_RST = 10'h014;
  localparam logic [9:0] WLVL_MIN = 10'h001;
  localparam logic [9:0] WLVL_MAX = 10'h064;
  localparam logic [9:0] WLVL_RST = 10'h014;
  localparam logic [9:0] DER_MIN = 10'h00a;
  localparam logic [9:0] DER_MAX = 10'h064;
  localparam logic [9:0] DER_RST = 10'h064;
  localparam logic [6:0] FULL_PCT = 7'h64;

  // ----------------------------------------------------------------
  // Fixed overload characteristic
  // ----------------------------------------------------------------
  localparam logic [23:0] OL_TRIP = 24'h0186a0;
  localparam logic [9:0] HI_PCT = 10'h12c;
  localparam logic [9:0] HI_MS = 10'h00a;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned EV_UV = 0;
  localparam int unsigned EV_OLW = 1;
  localparam int unsigned EV_LO = 2;
  localparam int unsigned EV_HI = 3;
  localparam int unsigned EV_CUT = 4;

  typedef enum logic [1:0] {UV_OFF, UV_HOST, UV_INT} uv_mode_t;
  typedef enum logic [1:0] {LIM_FREE, LIM_CLAMP, LIM_RELEASE} lim_state_t;

endpackage

// [core/uv_ol_guard.sv]
/*
  Undervoltage force limit, power cut hold and motor overload timing.
  Assumes a register port master on mclk, power stage pins that are
  asynchronous, and motor current already in mclk's domain.
*/
`timescale 1ns/1ps
module uv_ol_guard #(
  parameter int unsigned MS_CYCLES = uv_ol_pkg::CYC_PER_MS
)(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  // Power stage pins
  input  wire logic                          uv_sense,
  input  wire logic                          mains_lost,
  // Current feedback, percent of motor base current
  input  wire logic [uv_ol_pkg::CUR_W-1:0]   motor_current_pct,
  // Drive outputs
  output logic      [uv_ol_pkg::PCT_W-1:0]   force_limit_pct,
  output logic                               uv_warn,
  output logic                               warn_n,
  output logic                               motor_power_en,
  output logic                               servo_ready,
  output logic                               irq
);
  import uv_ol_pkg::*;

  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);

  function automatic logic [9:0] sat(input logic [31:0] v,
                                     input logic [9:0]  lo,
                                     input logic [9:0]  hi);
    if (v < 32'(lo))
      return lo;
    else if (v > 32'(hi))
      return hi;
    else
      return v[9:0];
  endfunction

  function automatic logic [6:0] ramp_pct(input logic [6:0] dip,
                                          input logic [9:0] el,
                                          input logic [9:0] rel);
    logic [16:0] span;
    span = 17'(FULL_PCT - dip) * 17'(el);
    return dip + 7'(span / 17'(rel));
  endfunction

  // ----------------------------------------------------------------
  // Reset release and millisecond tick
  // ----------------------------------------------------------------
  logic [1:0]     rst_sync_q;
  logic           rst_core_b;
  logic [MSW-1:0] ms_cnt_q;
  logic           ms_tick;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  assign rst_core_b = rst_sync_q[1];

  assign ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      ms_cnt_q <= '0;
    else if (ms_tick)
      ms_cnt_q <= '0;
    else
      ms_cnt_q <= ms_cnt_q + MSW'(1);

  // ----------------------------------------------------------------
  // Pin synchronisers: bit 0 undervoltage, bit 1 mains cut
  // ----------------------------------------------------------------
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_q;

  // Accept a change only once stages two and three agree
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {mains_lost, uv_sense};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  logic [1:0]     mode_set_q;
  uv_mode_t       mode_q;
  logic [6:0]     dip_q;
  logic [9:0]     rel_q;
  logic [9:0]     hold_q;
  logic [6:0]     wlvl_q;
  logic [6:0]     der_set_q;
  logic [6:0]     der_q;
  logic [NEV-1:0] mask_q;
  logic           restart;

  assign restart = reg_wr && reg_addr == OFS_RESTART && reg_wdata[0];

  // Code 3 is not a mode, so such a write is dropped
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      mode_set_q <= 2'h0;
      dip_q <= DIP_RST[6:0];
      rel_q <= REL_RST;
      hold_q <= HOLD_RST;
      wlvl_q <= WLVL_RST[6:0];
      der_set_q <= DER_RST[6:0];
      mask_q <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_MODE:
          if (reg_wdata[1:0] != 2'h3)
            mode_set_q <= reg_wdata[1:0];
        OFS_DIP:      dip_q <= 7'(sat(reg_wdata, DIP_MIN, DIP_MAX));
        OFS_REL:      rel_q <= sat(reg_wdata, REL_MIN, REL_MAX);
        OFS_HOLD:     hold_q <= sat(reg_wdata, HOLD_MIN, HOLD_MAX);
        OFS_WLVL:     wlvl_q <= 7'(sat(reg_wdata, WLVL_MIN, WLVL_MAX));
        OFS_DERATE:   der_set_q <= 7'(sat(reg_wdata, DER_MIN, DER_MAX));
        OFS_IRQ_MASK: mask_q <= reg_wdata[NEV-1:0];
        default:      ;
      endcase
    end

  // Mode and derating reach the logic only at restart
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      mode_q <= UV_OFF;
      der_q <= DER_RST[6:0];
    end
    else if (restart)
    begin
      mode_q <= uv_mode_t'(mode_set_q);
      der_q <= der_set_q;
    end

  // ----------------------------------------------------------------
  // Undervoltage warning and force limit
  // ----------------------------------------------------------------
  lim_state_t lim_q;
  logic [9:0] el_q;
  logic [9:0] el_nx;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      uv_warn <= 1'b0;
    else
      uv_warn <= pin_q[0] && mode_q != UV_OFF;

  assign el_nx = el_q + 10'h001;

  // Host mode leaves the limit at full scale; the host clamps
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      lim_q <= LIM_FREE;
      el_q <= 10'h000;
      force_limit_pct <= FULL_PCT;
    end
    else if (mode_q != UV_INT)
    begin
      lim_q <= LIM_FREE;
      force_limit_pct <= FULL_PCT;
    end
    else
    begin
      unique case (lim_q)
        LIM_FREE:
          if (uv_warn)
          begin
            lim_q <= LIM_CLAMP;
            force_limit_pct <= dip_q;
          end
        LIM_CLAMP:
          if (uv_warn)
            force_limit_pct <= dip_q;
          else if (rel_q == 10'h000)
          begin
            lim_q <= LIM_FREE;
            force_limit_pct <= FULL_PCT;
          end
          else
          begin
            lim_q <= LIM_RELEASE;
            el_q <= 10'h000;
          end
        LIM_RELEASE:
          if (uv_warn)
          begin
            lim_q <= LIM_CLAMP;
            force_limit_pct <= dip_q;
          end
          else if (ms_tick && el_nx >= rel_q)
          begin
            lim_q <= LIM_FREE;
            force_limit_pct <= FULL_PCT;
          end
          else if (ms_tick)
          begin
            el_q <= el_nx;
            force_limit_pct <= ramp_pct(dip_q, el_nx, rel_q);
          end
      endcase
    end

  // ----------------------------------------------------------------
  // Mains cut hold
  // ----------------------------------------------------------------
  logic [10:0] cut_ms_q;
  logic        cut_long;

  assign cut_long = pin_q[1] && cut_ms_q > {1'b0, hold_q};

  // Resolution is one tick; a cut may start mid-millisecond
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      cut_ms_q <= 11'h000;
    else if (!pin_q[1])
      cut_ms_q <= 11'h000;
    else if (ms_tick && cut_ms_q != 11'h7ff)
      cut_ms_q <= cut_ms_q + 11'h001;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      motor_power_en <= 1'b1;
    else if (cut_long)
      motor_power_en <= 1'b0;
    else if (!pin_q[1])
      motor_power_en <= 1'b1;

  // ----------------------------------------------------------------
  // Overload accumulation
  // ----------------------------------------------------------------
  logic [23:0] acc_q;
  logic [9:0]  der_w;
  logic [23:0] diff;
  logic        over;
  logic        warn_hit;
  logic        lo_alarm_q;
  logic        hi_alarm_q;
  logic        ol_warn_q;
  logic [9:0]  hi_ms_q;

  assign der_w = {3'h0, der_q};
  assign over = motor_current_pct > der_w;
  assign diff = over ? 24'(motor_current_pct - der_w)
                     : 24'(der_w - motor_current_pct);
  // Warning is a fraction of the same trip, so derating moves both
  assign warn_hit = 32'(acc_q) * 32'd100 >= 32'(OL_TRIP) * 32'(wlvl_q);

  // Cooling runs at the margin below the derated base
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      acc_q <= 24'h000000;
    else if (restart)
      acc_q <= 24'h000000;
    else if (ms_tick && over)
      acc_q <= (acc_q + diff > OL_TRIP) ? OL_TRIP : acc_q + diff;
    else if (ms_tick)
      acc_q <= (acc_q > diff) ? acc_q - diff : 24'h000000;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      ol_warn_q <= 1'b0;
      warn_n <= 1'b1;
    end
    else
    begin
      ol_warn_q <= warn_hit;
      warn_n <= !warn_hit;
    end

  // Alarms hold until restart
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      lo_alarm_q <= 1'b0;
    else if (restart)
      lo_alarm_q <= 1'b0;
    else if (acc_q >= OL_TRIP)
      lo_alarm_q <= 1'b1;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      hi_ms_q <= 10'h000;
    else if (motor_current_pct < HI_PCT)
      hi_ms_q <= 10'h000;
    else if (ms_tick && hi_ms_q != HI_MS)
      hi_ms_q <= hi_ms_q + 10'h001;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      hi_alarm_q <= 1'b0;
    else if (restart)
      hi_alarm_q <= 1'b0;
    else if (hi_ms_q == HI_MS)
      hi_alarm_q <= 1'b1;

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      servo_ready <= 1'b0;
    else
      servo_ready <= motor_power_en && !lo_alarm_q && !hi_alarm_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [NEV-1:0] ev;
  logic [NEV-1:0] ev_lvl_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] clr;

  assign ev = {!motor_power_en, hi_alarm_q, lo_alarm_q, ol_warn_q, uv_warn};
  assign clr = (reg_wr && reg_addr == OFS_IRQ_STAT)
             ? reg_wdata[NEV-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
    begin
      ev_lvl_q <= '0;
      stat_q <= '0;
    end
    else
    begin
      ev_lvl_q <= ev;
      stat_q <= (stat_q & ~clr) | (ev & ~ev_lvl_q);
    end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rmux;

  always_comb
  begin
    rmux = 32'h0;
    unique case (reg_addr)
      OFS_MODE:     rmux = {30'h0, mode_set_q};
      OFS_DIP:      rmux = {25'h0, dip_q};
      OFS_REL:      rmux = {22'h0, rel_q};
      OFS_HOLD:     rmux = {22'h0, hold_q};
      OFS_WLVL:     rmux = {25'h0, wlvl_q};
      OFS_DERATE:   rmux = {25'h0, der_set_q};
      OFS_STATUS:   rmux = {24'h0, mode_q, servo_ready, motor_power_en,
                            hi_alarm_q, lo_alarm_q, ol_warn_q, uv_warn};
      OFS_IRQ_STAT: rmux = {27'h0, stat_q};
      OFS_IRQ_MASK: rmux = {27'h0, mask_q};
      OFS_LIMIT:    rmux = {25'h0, force_limit_pct};
      OFS_ACC:      rmux = {8'h0, acc_q};
      default:      rmux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_core_b)
    if (!rst_core_b)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rmux : 32'h0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_core_b);

  sequence uv_onset;
    mode_q == UV_INT && $rose(uv_warn);
  endsequence

  sequence long_cut;
    pin_q[1] && cut_ms_q > {1'b0, hold_q};
  endsequence

  mode_off_a: assert property (
    mode_q == UV_OFF |=> !uv_warn)
    else $error("warning raised with detection off");

  uv_clamp_a: assert property (
    uv_onset |=> force_limit_pct == $past(dip_q))
    else $error("force not clamped on undervoltage");

  rel_done_a: assert property (
    mode_q == UV_INT && lim_q == LIM_RELEASE && !uv_warn && ms_tick
    && el_nx >= rel_q |=> force_limit_pct == FULL_PCT ##0
    lim_q == LIM_FREE)
    else $error("limit not released at release time");

  dip_range_a: assert property (
    dip_q <= DIP_MAX[6:0])
    else $error("dip limit out of range");

  hold_range_a: assert property (
    hold_q >= HOLD_MIN && hold_q <= HOLD_MAX)
    else $error("hold time out of range");

  hold_keep_a: assert property (
    motor_power_en && pin_q[1] && cut_ms_q <= {1'b0, hold_q}
    |=> motor_power_en)
    else $error("power dropped within hold time");

  cut_drop_a: assert property (
    long_cut |=> !motor_power_en ##1 !servo_ready)
    else $error("long cut did not drop power and ready");

  warn_time_a: assert property (
    warn_hit && !$past(warn_hit) |=> ol_warn_q ##0 !warn_n)
    else $error("overload warning late");

  lvl_range_a: assert property (
    wlvl_q >= WLVL_MIN[6:0] && wlvl_q <= WLVL_MAX[6:0])
    else $error("warning level out of range");

  warn_pin_a: assert property (
    ol_warn_q |-> !warn_n)
    else $error("warning pin not asserted");

  trip_fixed_a: assert property (
    acc_q >= OL_TRIP && !restart |=> lo_alarm_q)
    else $error("low load alarm missed at trip");

  acc_idle_a: assert property (
    ms_tick && !over && acc_q == 24'h0 && !restart |=> acc_q == 24'h0)
    else $error("accumulated below derated base");

  der_range_a: assert property (
    der_q >= DER_MIN[6:0] && der_q <= DER_MAX[6:0])
    else $error("derating out of range");

  acc_rate_a: assert property (
    ms_tick && over && !restart && acc_q + diff <= OL_TRIP
    |=> acc_q == $past(acc_q) + 24'($past(motor_current_pct))
        - 24'($past(der_w)))
    else $error("accumulation not tied to derated base");

endmodule

// [sim/host_ctrl_model.sv]
/*
  Host motion controller model: holds its own force limit while the
  drive shows the undervoltage warning.
  Assumes uv_warn is a registered level on mclk.
*/
`timescale 1ns/1ps
module host_ctrl_model
(
  // Clock
  input  wire logic       mclk,
  // Drive warning and host limit setting
  input  wire logic       uv_warn,
  input  wire logic [6:0] host_dip_pct,
  // Limit the host applies
  output logic      [6:0] host_limit_pct
);
  // Limit is lifted only once the warning has gone
  always_ff @(posedge mclk)
  begin
    if (uv_warn)
      host_limit_pct <= host_dip_pct;
    else
      host_limit_pct <= 7'h64;
  end
endmodule

// [sim/uv_ol_guard_tb.sv]
/*
  Self-checking bench for uv_ol_guard: register tasks, undervoltage,
  mains cut and overload scenarios beside a host controller model.
  Assumes MS_CYCLES shortened to 40 clocks per ms tick.
*/
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module uv_ol_guard_tb;
  import uv_ol_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  localparam int MSC = 40;
  logic              mclk, rst_b, reg_wr, reg_rd, uv_sense, mains_lost;
  logic              uv_warn, warn_n, pwr, rdy, irq;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d;
  logic [CUR_W-1:0]  cur;
  logic [PCT_W-1:0]  lim, host_lim;
  int                checks = 0;
  int                error_cnt = 0;
  logic [7:0]        oa [5] = '{OFS_DIP, OFS_REL, OFS_HOLD, OFS_WLVL,
                                OFS_DERATE};
  logic [31:0]       rv [5] = '{32'h32, 32'h64, 32'h14, 32'h14, 32'h64};
  logic [31:0]       sv [5] = '{32'hc8, 32'h3e9, 32'h5, 32'h0, 32'h5};
  logic [31:0]       se [5] = '{32'h64, 32'h3e8, 32'h14, 32'h1, 32'ha};

  uv_ol_guard #(.MS_CYCLES(MSC)) uv_ol_guard_i (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .uv_sense(uv_sense), .mains_lost(mains_lost),
    .motor_current_pct(cur), .force_limit_pct(lim), .uv_warn(uv_warn),
    .warn_n(warn_n), .motor_power_en(pwr), .servo_ready(rdy), .irq(irq));

  host_ctrl_model host_ctrl_model_i (
    .mclk(mclk), .uv_warn(uv_warn), .host_dip_pct(7'h1e),
    .host_limit_pct(host_lim));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask

  task automatic ms(input int n);
    repeat (n * MSC) @(posedge mclk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    {rst_b, reg_wr, reg_rd, uv_sense, mains_lost} = 5'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    cur = '0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 5; i++) rchk(oa[i], rv[i]);
    rchk(8'h30, 32'h0);
    // Read data stand one cycle only
    @(posedge mclk);
    #1;
    `CHK(reg_rdata, 32'h0)
    for (int i = 0; i < 5; i++)
    begin
      wr(oa[i], sv[i]);
      rchk(oa[i], se[i]);
    end
    wr(OFS_DIP, 32'h1e);
    wr(OFS_REL, 32'ha);
    wr(OFS_WLVL, 32'h14);
    wr(OFS_DERATE, 32'h64);
    wr(OFS_IRQ_MASK, 32'h0);
    // Mode off ignores the sense pin
    uv_sense <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    `CHK({uv_warn, lim}, 8'h64)
    uv_sense <= 1'b0;
    wr(OFS_MODE, 32'h2);
    rd(OFS_STATUS);
    `CHK(d[7:6], 2'h0)
    wr(OFS_RESTART, 32'h1);
    rd(OFS_STATUS);
    `CHK(d[7:6], 2'h2)
    uv_sense <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK({uv_warn, lim, irq}, 9'h13c)
    ms(3);
    `CHK(lim, 7'h1e)
    rchk(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    uv_sense <= 1'b0;
    ms(5);
    `CHK((lim > 7'h1e) && (lim < 7'h64), 1'b1)
    ms(8);
    `CHK(lim, 7'h64)
    // Host mode leaves the clamp to the controller
    wr(OFS_MODE, 32'h1);
    wr(OFS_MODE, 32'h3);
    rchk(OFS_MODE, 32'h1);
    wr(OFS_RESTART, 32'h1);
    uv_sense <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK({uv_warn, lim, host_lim}, 15'h721e)
    uv_sense <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    `CHK({uv_warn, host_lim}, 8'h64)
    // Mains cut shorter and longer than hold
    `CHK({pwr, rdy}, 2'h3)
    mains_lost <= 1'b1;
    ms(10);
    `CHK(pwr, 1'b1)
    mains_lost <= 1'b0;
    ms(2);
    mains_lost <= 1'b1;
    ms(30);
    `CHK({pwr, rdy}, 2'h0)
    mains_lost <= 1'b0;
    ms(2);
    `CHK(pwr, 1'b1)
    // Derated base current, latched at restart
    wr(OFS_DERATE, 32'h32);
    cur <= 10'h3c;
    ms(5);
    rchk(OFS_ACC, 32'h0);
    wr(OFS_RESTART, 32'h1);
    ms(10);
    rd(OFS_ACC);
    `CHK((d >= 32'h50) && (d <= 32'h6e), 1'b1)
    cur <= 10'hc8;
    wr(OFS_RESTART, 32'h1);
    ms(125);
    `CHK(warn_n, 1'b1)
    ms(17);
    `CHK(warn_n, 1'b0)
    wr(OFS_DERATE, 32'h64);
    wr(OFS_RESTART, 32'h1);
    ms(100);
    `CHK(warn_n, 1'b1)
    wr(OFS_WLVL, 32'h5);
    repeat (3) @(posedge mclk);
    #1;
    `CHK(warn_n, 1'b0)
    // Fixed high-load trip
    wr(OFS_WLVL, 32'h14);
    cur <= 10'h12c;
    wr(OFS_RESTART, 32'h1);
    ms(8);
    rd(OFS_STATUS);
    `CHK(d[3], 1'b0)
    ms(4);
    rd(OFS_STATUS);
    `CHK({d[3], rdy}, 2'h2)
    // Low-load trip at the fixed accumulator ceiling
    cur <= 10'h3ff;
    wr(OFS_RESTART, 32'h1);
    ms(100);
    rd(OFS_STATUS);
    `CHK(d[2], 1'b0)
    ms(12);
    rd(OFS_STATUS);
    `CHK(d[2], 1'b1)
    stop_test();
  end
endmodule
